// *** logic/vms_top.sv ***
// Notes on behaviour
// - Clearing request returns real if axes stopped at switch end
// - Forced stop, ready loss, servo error return
// - Failed user switch sets error and code
// - Continue mode keeps faulty axis drive running
// - Refuse motion commands while switching
// - Test mode ignores request flag transitions
// - Test mode takes peripheral switch, same checks
// - Status flag follows mode in effect
// - Three stop methods: decel, rapid, immediate
// - Stop method applies to interpolation partners
// - Encoder axis input stops immediately
// - Sync discrepancy cause sets warning flag
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "vms_defs.svh"
module vms_top
    import vms_pkg::*;
#(
    parameter int NAX = `VMS_NAX,
    parameter logic [15:0] SWITCH_CYC = 16'(`VMS_SWITCH_CYC)
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic forced_stop,
    input wire logic wdt_error,
    input wire logic [NAX-1:0] servo_error,
    input wire logic [NAX-1:0] axis_start_accept,
    input wire logic [NAX-1:0] interp_link,
    input wire logic cmd_req,
    output logic cmd_accept,
    output logic cmd_refuse,
    output logic mode_switch_status,
    output logic switch_busy,
    output logic [NAX-1:0] axis_decel_stop,
    output logic [NAX-1:0] axis_rapid_stop,
    output logic [NAX-1:0] axis_immediate_stop,
    output logic encoder_input_stop,
    output logic [NAX-1:0] drive_keep_running,
    output logic irq
);

    localparam int SW = 2 + 3 * NAX;

    typedef struct packed {
        vms_mode_t st;
        logic [SW-1:0] sync1;
        logic [SW-1:0] sync2;
        logic mode_switch_request;
        logic host_ready_flag;
        logic all_axes_servo_on_command;
        logic cont_virt;
        logic [NAX-1:0] stop_cmd;
        logic [NAX-1:0] rapid_cmd;
        logic test_mode;
        logic test_req;
        logic test_mode_d;
        logic prev_req;
        logic auto_ret;
        logic [15:0] cnt;
        logic mode_switch_error_flag;
        logic [15:0] err_info;
        logic sync_discrepancy_warning;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic cmd_accept;
        logic cmd_refuse;
        logic status;
        logic busy;
        logic [NAX-1:0] dec_o;
        logic [NAX-1:0] rap_o;
        logic [NAX-1:0] imm_o;
        logic enc_stop;
        logic [NAX-1:0] keep_run;
        logic irq;
    } vms_state_t;

    vms_state_t s;
    vms_state_t next_s;

    logic f_stop;
    logic wdt;
    logic [NAX-1:0] serr;
    logic [NAX-1:0] busy_ax;
    logic [NAX-1:0] interp;
    logic virt;
    logic all_dec;
    logic all_rap;
    logic all_imm;
    logic [NAX-1:0] dec_raw;
    logic [NAX-1:0] rap_raw;
    logic [NAX-1:0] dec_grp;
    logic [NAX-1:0] rap_grp;
    logic [NAX-1:0] keep_raw;

    assign f_stop = s.sync2[0];
    assign wdt = s.sync2[1];
    assign serr = s.sync2[2 +: NAX];
    assign busy_ax = s.sync2[2 + NAX +: NAX];
    assign interp = s.sync2[2 + 2 * NAX +: NAX];

    assign virt = (s.st == VMS_VIRTUAL) || (s.st == VMS_TO_REAL);
    assign all_dec = !s.all_axes_servo_on_command || !s.host_ready_flag;
    assign all_rap = f_stop || ((|serr) && !s.cont_virt);
    assign all_imm = wdt;

    genvar gi;
    generate
        for (gi = 0; gi < NAX; gi++)
        begin : g_axis
            assign dec_raw[gi] = virt && (s.stop_cmd[gi] || all_dec);
            assign rap_raw[gi] = virt && (s.rapid_cmd[gi] || all_rap);
            assign dec_grp[gi] = dec_raw[gi] || (interp[gi] && |(interp & dec_raw));
            assign rap_grp[gi] = rap_raw[gi] || (interp[gi] && |(interp & rap_raw));
            assign keep_raw[gi] = virt && s.cont_virt && serr[gi];
        end
    endgenerate

    logic acc;
    logic wr;
    logic eff_req;
    logic req_rise;
    logic req_fall;
    logic all_stopped;
    logic [31:0] rd;
    logic mapped;
    vms_events_t ev;

    always_comb
    begin
        next_s = s;
        ev = '0;
        rd = '0;
        mapped = 1'b1;
        next_s.sync1 = {interp_link, axis_start_accept, servo_error, wdt_error, forced_stop};
        next_s.sync2 = s.sync1;

        // Bus slave: one wait state, answer registered
        acc = psel && penable;
        wr = acc && s.pready && pwrite && !s.pslverr;
        case (paddr)
            `VMS_ADDR_CTRL:
            begin
                rd[`VMS_CTRL_REQ] = s.mode_switch_request;
                rd[`VMS_CTRL_READY] = s.host_ready_flag;
                rd[`VMS_CTRL_SERVO_ON] = s.all_axes_servo_on_command;
                rd[`VMS_CTRL_CONT_VIRT] = s.cont_virt;
            end
            `VMS_ADDR_STATUS:
            begin
                rd[`VMS_STAT_MODE] = s.status;
                rd[`VMS_STAT_BUSY] = s.busy;
                rd[`VMS_STAT_ERR] = s.mode_switch_error_flag;
                rd[`VMS_STAT_SYNC] = s.sync_discrepancy_warning;
            end
            `VMS_ADDR_IRQ_STAT: rd[3:0] = s.irq_stat;
            `VMS_ADDR_IRQ_MASK: rd[3:0] = s.irq_mask;
            `VMS_ADDR_ERR_INFO: rd[15:0] = s.err_info;
            `VMS_ADDR_STOP:
            begin
                rd[NAX-1:0] = s.stop_cmd;
                rd[`VMS_STOP_RAPID_POS +: NAX] = s.rapid_cmd;
            end
            `VMS_ADDR_TEST:
            begin
                rd[`VMS_TEST_MODE] = s.test_mode;
                rd[`VMS_TEST_REQ] = s.test_req;
            end
            default: mapped = 1'b0;
        endcase
        next_s.pready = acc && !s.pready;
        if (acc && !s.pready)
        begin
            next_s.prdata = rd;
            next_s.pslverr = !mapped;
        end
        else
        begin
            next_s.pslverr = 1'b0;
        end

        if (wr)
        begin
            case (paddr)
                `VMS_ADDR_CTRL:
                begin
                    next_s.mode_switch_request = pwdata[`VMS_CTRL_REQ];
                    next_s.host_ready_flag = pwdata[`VMS_CTRL_READY];
                    next_s.all_axes_servo_on_command = pwdata[`VMS_CTRL_SERVO_ON];
                    next_s.cont_virt = pwdata[`VMS_CTRL_CONT_VIRT];
                end
                `VMS_ADDR_STATUS:
                begin
                    if (pwdata[`VMS_STAT_ERR])
                        next_s.mode_switch_error_flag = 1'b0;
                    if (pwdata[`VMS_STAT_SYNC])
                        next_s.sync_discrepancy_warning = 1'b0;
                end
                `VMS_ADDR_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~pwdata[3:0];
                `VMS_ADDR_IRQ_MASK: next_s.irq_mask = pwdata[3:0];
                `VMS_ADDR_STOP:
                begin
                    next_s.stop_cmd = pwdata[NAX-1:0];
                    next_s.rapid_cmd = pwdata[`VMS_STOP_RAPID_POS +: NAX];
                end
                `VMS_ADDR_TEST:
                begin
                    next_s.test_mode = pwdata[`VMS_TEST_MODE];
                    next_s.test_req = pwdata[`VMS_TEST_REQ];
                end
                default: ;
            endcase
        end

        // peripheral request replaces the flag in test mode
        eff_req = s.test_mode ? s.test_req : s.mode_switch_request;
        next_s.test_mode_d = s.test_mode;
        next_s.prev_req = eff_req;
        // source change itself is no transition
        req_rise = eff_req && !s.prev_req && (s.test_mode == s.test_mode_d);
        req_fall = !eff_req && s.prev_req && (s.test_mode == s.test_mode_d);
        all_stopped = ~|busy_ax;
        if (s.cnt != 16'h0000)
            next_s.cnt = s.cnt - 16'h0001;

        case (s.st)
            VMS_REAL:
            begin
                if (req_rise)
                begin
                    next_s.st = VMS_TO_VIRT;
                    next_s.cnt = SWITCH_CYC;
                end
            end
            VMS_TO_VIRT:
            begin
                if (s.cnt == 16'h0000)
                begin
                    if (all_stopped && s.host_ready_flag)
                    begin
                        next_s.st = VMS_VIRTUAL;
                        ev.done = 1'b1;
                    end
                    else
                    begin
                        next_s.st = VMS_REAL;
                        ev.err = 1'b1;
                        next_s.err_info = all_stopped ? `VMS_ERR_NOT_READY : `VMS_ERR_AXIS_BUSY;
                    end
                end
            end
            VMS_VIRTUAL:
            begin
                if (f_stop || !s.host_ready_flag || ((|serr) && !s.cont_virt))
                begin
                    next_s.st = VMS_TO_REAL;
                    next_s.auto_ret = 1'b1;
                    next_s.cnt = SWITCH_CYC;
                    ev.auto_ret = 1'b1;
                    if (f_stop)
                        next_s.err_info = `VMS_ERR_AUTO_FORCED;
                    else if (!s.host_ready_flag)
                        next_s.err_info = `VMS_ERR_AUTO_READY;
                    else
                        next_s.err_info = `VMS_ERR_AUTO_SERVO;
                end
                else if (req_fall)
                begin
                    next_s.st = VMS_TO_REAL;
                    next_s.auto_ret = 1'b0;
                    next_s.cnt = SWITCH_CYC;
                end
            end
            VMS_TO_REAL:
            begin
                // real mode only once all axes stopped
                if (s.cnt == 16'h0000)
                begin
                    if (all_stopped)
                    begin
                        next_s.st = VMS_REAL;
                        next_s.auto_ret = 1'b0;
                        ev.done = 1'b1;
                    end
                    else if (!s.auto_ret)
                    begin
                        next_s.st = VMS_VIRTUAL;
                        ev.err = 1'b1;
                        next_s.err_info = `VMS_ERR_AXIS_BUSY;
                    end
                end
            end
            default: next_s.st = VMS_REAL;
        endcase

        ev.sync = virt && (f_stop || (|serr)) && !s.sync_discrepancy_warning;
        if (ev.sync)
            next_s.sync_discrepancy_warning = 1'b1;
        if (ev.err)
            next_s.mode_switch_error_flag = 1'b1;
        next_s.irq_stat = next_s.irq_stat | {ev.sync, ev.auto_ret, ev.err, ev.done};
        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

        // status changes only when switch done
        next_s.status = (next_s.st == VMS_VIRTUAL) || (next_s.st == VMS_TO_REAL);
        next_s.busy = (next_s.st == VMS_TO_VIRT) || (next_s.st == VMS_TO_REAL);
        next_s.cmd_accept = cmd_req && !s.busy;
        next_s.cmd_refuse = cmd_req && s.busy;

        next_s.imm_o = virt && all_imm ? {NAX{1'b1}} : '0;
        next_s.rap_o = (virt && all_imm) ? '0 : (rap_grp & ~keep_raw);
        next_s.dec_o = (virt && all_imm) ? '0 : (dec_grp & ~rap_grp & ~keep_raw);
        next_s.keep_run = keep_raw;
        next_s.enc_stop = virt && (all_dec || all_rap || all_imm);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign cmd_accept = s.cmd_accept;
    assign cmd_refuse = s.cmd_refuse;
    assign mode_switch_status = s.status;
    assign switch_busy = s.busy;
    assign axis_decel_stop = s.dec_o;
    assign axis_rapid_stop = s.rap_o;
    assign axis_immediate_stop = s.imm_o;
    assign encoder_input_stop = s.enc_stop;
    assign drive_keep_running = s.keep_run;
    assign irq = s.irq;

endmodule
`default_nettype wire

// *** include/vms_defs.svh ***
`ifndef VMS_DEFS_SVH
`define VMS_DEFS_SVH

`define VMS_NAX 4
`define VMS_CLK_NS 8
`define VMS_SWITCH_NS 2000
`define VMS_SWITCH_CYC ((`VMS_SWITCH_NS + `VMS_CLK_NS - 1) / `VMS_CLK_NS)

`define VMS_ADDR_CTRL 8'h00
`define VMS_ADDR_STATUS 8'h04
`define VMS_ADDR_IRQ_STAT 8'h08
`define VMS_ADDR_IRQ_MASK 8'h0C
`define VMS_ADDR_ERR_INFO 8'h10
`define VMS_ADDR_STOP 8'h14
`define VMS_ADDR_TEST 8'h18

`define VMS_CTRL_REQ 0
`define VMS_CTRL_READY 1
`define VMS_CTRL_SERVO_ON 2
`define VMS_CTRL_CONT_VIRT 3
`define VMS_STAT_MODE 0
`define VMS_STAT_BUSY 1
`define VMS_STAT_ERR 2
`define VMS_STAT_SYNC 3
`define VMS_STOP_RAPID_POS 8
`define VMS_TEST_MODE 0
`define VMS_TEST_REQ 1

`define VMS_ERR_NONE 16'h0000
`define VMS_ERR_AXIS_BUSY 16'h0001
`define VMS_ERR_NOT_READY 16'h0002
`define VMS_ERR_AUTO_FORCED 16'h0003
`define VMS_ERR_AUTO_READY 16'h0004
`define VMS_ERR_AUTO_SERVO 16'h0005

`endif

// *** include/vms_pkg.sv ***
package vms_pkg;

    typedef enum logic [1:0] {
        VMS_REAL,
        VMS_TO_VIRT,
        VMS_VIRTUAL,
        VMS_TO_REAL
    } vms_mode_t;

    typedef struct packed {
        logic done;
        logic err;
        logic auto_ret;
        logic sync;
    } vms_events_t;

endpackage

// *** bench/vms_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module vms_checker #(
    parameter int NAX = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdt_error,
    input wire logic forced_stop,
    input wire logic cmd_req,
    input wire logic cmd_accept,
    input wire logic cmd_refuse,
    input wire logic mode_switch_status,
    input wire logic switch_busy,
    input wire logic [NAX-1:0] axis_decel_stop,
    input wire logic [NAX-1:0] axis_rapid_stop,
    input wire logic [NAX-1:0] axis_immediate_stop,
    input wire logic encoder_input_stop,
    input wire logic [NAX-1:0] drive_keep_running
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
property p_ans; psel && penable && !pready |=> pready; endproperty
a_ans: assert property (p_ans) else $error("apb access not answered");
property p_err; pslverr |-> pready; endproperty
a_err: assert property (p_err) else $error("slave error without ready");
property p_acc; cmd_req && !switch_busy |=> cmd_accept && !cmd_refuse; endproperty
a_acc: assert property (p_acc) else $error("command not accepted");
property p_ref; cmd_req && switch_busy |=> cmd_refuse && !cmd_accept; endproperty
a_ref: assert property (p_ref) else $error("command not refused");
property p_stat; $changed(mode_switch_status) |-> $fell(switch_busy); endproperty
a_stat: assert property (p_stat) else $error("status moved early");
property p_imm; (axis_immediate_stop & (axis_rapid_stop | axis_decel_stop)) == '0; endproperty
a_imm: assert property (p_imm) else $error("stop methods overlap");
property p_wdt;
    wdt_error [*4] ##0 (mode_switch_status && !switch_busy)
        |-> &axis_immediate_stop && encoder_input_stop;
endproperty
a_wdt: assert property (p_wdt) else $error("no immediate stop");
property p_auto;
    forced_stop [*3] ##0 (mode_switch_status && !switch_busy) |-> ##[0:3] switch_busy;
endproperty
a_auto: assert property (p_auto) else $error("no return to real");
property p_keep; (drive_keep_running & axis_rapid_stop) == '0; endproperty
a_keep: assert property (p_keep) else $error("kept axis stopped");
c_ref: cover property (cmd_req ##1 cmd_refuse);
c_imm: cover property (&axis_immediate_stop);
c_ret: cover property ($fell(mode_switch_status));
endmodule
bind vms_top vms_checker #(.NAX(NAX)) i_vms_checker (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .wdt_error, .forced_stop, .cmd_req, .cmd_accept, .cmd_refuse,
    .mode_switch_status, .switch_busy, .axis_decel_stop, .axis_rapid_stop,
    .axis_immediate_stop, .encoder_input_stop, .drive_keep_running);
`default_nettype wire

// *** bench/vms_axes_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module vms_axes_model #(
    parameter int NAX = 4,
    parameter int LAG = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NAX-1:0] start,
    input wire logic [NAX-1:0] stop,
    output logic [NAX-1:0] moving
);
int cnt [NAX];
// Axis runs from start until a stop has been held LAG+1 cycles
always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
        moving <= '0;
    else
        for (int i = 0; i < NAX; i++)
            if (start[i])
            begin
                moving[i] <= 1'b1;
                cnt[i] <= LAG;
            end
            else if (moving[i] && stop[i])
            begin
                if (cnt[i] == 0)
                    moving[i] <= 1'b0;
                cnt[i] <= cnt[i] - 1;
            end
endmodule
`default_nettype wire

// *** bench/test_virtual_mode_switch_and_stop.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "vms_defs.svh"
module test_virtual_mode_switch_and_stop;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_req, cmd_accept;
logic cmd_refuse, forced_stop, wdt_error, mode_switch_status, switch_busy, irq, e;
logic encoder_input_stop;
logic [7:0] paddr;
logic [31:0] pwdata, prdata, q;
logic [3:0] servo_error, axis_start_accept, interp_link, start, halt;
logic [3:0] axis_decel_stop, axis_rapid_stop, axis_immediate_stop, drive_keep_running;
int err_count = 0;
int comparisons = 0;
int cyc = 0;
vms_top #(.NAX(4), .SWITCH_CYC(16'h0004)) i_vms_top (.pclk, .presetn, .ce(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .forced_stop,
    .wdt_error, .servo_error, .axis_start_accept, .interp_link, .cmd_req, .cmd_accept,
    .cmd_refuse, .mode_switch_status, .switch_busy, .axis_decel_stop, .axis_rapid_stop,
    .axis_immediate_stop, .encoder_input_stop, .drive_keep_running, .irq);
vms_axes_model #(.NAX(4), .LAG(3)) i_vms_axes_model (.pclk, .presetn, .start,
    .stop(axis_decel_stop | axis_rapid_stop | axis_immediate_stop | halt),
    .moving(axis_start_accept));
initial
begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
end
task final_report;
    if (err_count == 0 && comparisons > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
always @(posedge pclk)
begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
        err_count++;
        final_report;
    end
end
task chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x)
    begin
        err_count++;
        $display("[ERR] %0t got %h expected %h", $time, s, x);
    end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
        @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
endtask
task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
endtask
task wc(input int n);
    repeat (n) @(posedge pclk);
endtask
task wsw;
    wait (switch_busy === 1'b1);
    wait (switch_busy === 1'b0);
    wc(2);
endtask
task cmd(input logic x);
    cmd_req <= 1'b1;
    @(posedge pclk);
    cmd_req <= 1'b0;
    @(posedge pclk);
    chk(32'({cmd_accept, cmd_refuse}), 32'({~x, x}));
endtask
task t_regs;
    rd(`VMS_ADDR_CTRL, 32'h0);
    rd(`VMS_ADDR_STATUS, 32'h0);
    rd(`VMS_ADDR_IRQ_MASK, 32'h0);
    rd(8'h20, 32'h0);
    chk(32'(e), 32'h1);
endtask
task t_up;
    wr(`VMS_ADDR_IRQ_MASK, 32'h1);
    wr(`VMS_ADDR_CTRL, 32'h7);
    wait (switch_busy === 1'b1);
    @(posedge pclk);
    cmd(1'b1);
    chk(32'(mode_switch_status), 32'h0);
    wsw;
    chk(32'(mode_switch_status), 32'h1);
    chk(32'(irq), 32'h1);
    wr(`VMS_ADDR_IRQ_STAT, 32'h1);
    wc(2);
    chk(32'(irq), 32'h0);
    cmd(1'b0);
endtask
task t_stop;
    interp_link <= 4'h3;
    wr(`VMS_ADDR_STOP, 32'h0401);
    wc(2);
    chk(32'(axis_decel_stop), 32'h3);
    chk(32'(axis_rapid_stop), 32'h4);
    wr(`VMS_ADDR_STOP, 32'h0);
    interp_link <= 4'h0;
endtask
task t_fail;
    start <= 4'h2;
    @(posedge pclk);
    start <= 4'h0;
    wr(`VMS_ADDR_IRQ_MASK, 32'h2);
    wr(`VMS_ADDR_CTRL, 32'h6);
    wsw;
    chk(32'(mode_switch_status), 32'h1);
    rd(`VMS_ADDR_STATUS, 32'h5);
    rd(`VMS_ADDR_ERR_INFO, 32'h1);
    chk(32'(irq), 32'h1);
    wr(`VMS_ADDR_STATUS, 32'h4);
    wr(`VMS_ADDR_IRQ_STAT, 32'h2);
    rd(`VMS_ADDR_STATUS, 32'h1);
    halt <= 4'h2;
    wc(6);
    halt <= 4'h0;
endtask
task t_test;
    wr(`VMS_ADDR_TEST, 32'h3);
    wr(`VMS_ADDR_CTRL, 32'h3);
    wr(`VMS_ADDR_CTRL, 32'h2);
    wc(30);
    chk(32'(mode_switch_status), 32'h1);
    wr(`VMS_ADDR_TEST, 32'h1);
    wsw;
    chk(32'(mode_switch_status), 32'h0);
    wr(`VMS_ADDR_TEST, 32'h0);
endtask
task t_auto;
    wr(`VMS_ADDR_CTRL, 32'h7);
    wsw;
    wdt_error <= 1'b1;
    wc(6);
    chk(32'(axis_immediate_stop), 32'hF);
    chk(32'(encoder_input_stop), 32'h1);
    wdt_error <= 1'b0;
    wc(4);
    forced_stop <= 1'b1;
    wsw;
    chk(32'(mode_switch_status), 32'h0);
    rd(`VMS_ADDR_ERR_INFO, 32'h3);
    rd(`VMS_ADDR_STATUS, 32'h8);
    forced_stop <= 1'b0;
    wc(4);
    wr(`VMS_ADDR_STATUS, 32'h8);
    rd(`VMS_ADDR_STATUS, 32'h0);
endtask
task t_cont;
    wr(`VMS_ADDR_CTRL, 32'hE);
    wc(30);
    wr(`VMS_ADDR_CTRL, 32'hF);
    wsw;
    servo_error <= 4'h4;
    wc(6);
    chk(32'(drive_keep_running), 32'h4);
    chk(32'(mode_switch_status), 32'h1);
    halt <= 4'h4;
    @(posedge pclk);
    servo_error <= 4'h0;
    halt <= 4'h0;
    wr(`VMS_ADDR_CTRL, 32'hD);
    wsw;
    chk(32'(mode_switch_status), 32'h0);
    rd(`VMS_ADDR_ERR_INFO, 32'h4);
endtask
initial
begin
    presetn = 1'b0;
    {psel, penable, pwrite, cmd_req, forced_stop, wdt_error} = '0;
    {paddr, pwdata, servo_error, interp_link, start, halt} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wc(3);
    t_regs;
    t_up;
    t_stop;
    t_fail;
    t_test;
    t_auto;
    t_cont;
    final_report;
end
endmodule
`default_nettype wire
